//--- bbl_move_defs.vh
// constants for the byte and bit move decode and execute unit
// Operation
// RULE1 - general byte load copies source to destination; source left untouched
// RULE2 - high nibble names working register; low nibble C, 8, 9; 2 bytes, 4 cycles
// RULE3 - none of these moves ever writes the flag register
// RULE4 - bit load direction: source register bit b goes to working register bit 0
// RULE5 - bit store direction: working register bit 0 goes to register bit b
// RULE6 - bit move keeps other destination bits; source never written
// RULE7 - bit move opcode 47, 3 bytes, 6 cycles; reg, bit, direction fields
// RULE8 - memory move copies one byte between memory and working register
// RULE9 - even pointer pair selects program memory, odd pair selects data memory
// RULE10 - pair indirect memory move: C3 load, D3 store, 2 bytes, 10 cycles
// RULE11 - short indexed memory move: E7 load, F7 store, 3 bytes, 12 cycles
// RULE12 - long indexed memory move: A7 load, B7 store, offset low first, 14 cycles
// RULE13 - long indexed pair 0-1 is reserved and decodes as direct address
// RULE14 - A7/B7 with pair 0000 direct program address, 0001 direct data address
// RULE15 - indexed address is working register pair plus instruction offset
`ifndef BBL_MOVE_DEFS_VH
`define BBL_MOVE_DEFS_VH
// low nibble opcodes of the one byte opcode general load forms
`define BBL_NIB_IMM 4'hC
`define BBL_NIB_FROM 4'h8
`define BBL_NIB_TO 4'h9
// full opcodes
`define BBL_OP_BIT 8'h47
`define BBL_OP_PTR_LOAD 8'hC3
`define BBL_OP_PTR_STORE 8'hD3
`define BBL_OP_SX_LOAD 8'hE7
`define BBL_OP_SX_STORE 8'hF7
`define BBL_OP_LX_LOAD 8'hA7
`define BBL_OP_LX_STORE 8'hB7
// cycle counts per form
`define BBL_CYC_REG 4'h4
`define BBL_CYC_BIT 4'h6
`define BBL_CYC_PTR 4'hA
`define BBL_CYC_SX 4'hC
`define BBL_CYC_LX 4'hE
`define BBL_CYC_NONE 4'h0
// step counter start, increment and end-of-form leads
`define BBL_CNT_ZERO 4'h0
`define BBL_CNT_STEP 4'h1
`define BBL_WRITE_LEAD 4'h2
`define BBL_DONE_LEAD 4'h1
// sequence steps
`define BBL_STEP_RD_A 4'h0
`define BBL_STEP_RD_B 4'h1
`define BBL_STEP_RD_C 4'h2
`define BBL_STEP_MEM 4'h3
`define BBL_STEP_MDATA 4'h5
// pair field upper bits that mean direct address under A7/B7
`define BBL_DIRECT_PAIR 3'h0
// direction bit value for store into register bit
`define BBL_DIR_STORE 1'b1
`define BBL_ZERO_BYTE 8'h00
`define BBL_ZERO_WORD 16'h0000
`endif

//--- bbl_move_unit.v
// byte, bit and memory move decode and execute unit
`timescale 1ns/1ps
`default_nettype none
`include "bbl_move_defs.vh"
module bbl_move_unit (
  // clock and reset
  input wire CORE_CLK,
  input wire RESET,
  // instruction issue
  input wire START,
  input wire [31:0] INSTR,
  input wire [7:0] WREG_BASE,
  output wire BUSY,
  output reg DONE,
  output reg ILLEGAL,
  // register file
  output reg [7:0] REG_RADDR,
  input wire [7:0] REG_RDATA,
  output reg REG_WE,
  output reg [7:0] REG_WADDR,
  output reg [7:0] REG_WDATA,
  output reg FLAGS_WE,
  // program and data memory
  output reg MEM_REQ,
  output reg MEM_WE,
  output reg MEM_SPACE,
  output reg [15:0] MEM_ADDR,
  output reg [7:0] MEM_WDATA,
  input wire [7:0] MEM_RDATA
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state;
  reg [3:0] cnt;
  reg [31:0] ins;
  reg [7:0] a_val;
  reg [7:0] b_val;
  reg [7:0] mdata;

  // cycle count per opcode, zero for anything this unit does not execute
  function [3:0] bbl_len;
    input [7:0] o;
    begin
      if (o[3:0] == `BBL_NIB_IMM || o[3:0] == `BBL_NIB_FROM || o[3:0] == `BBL_NIB_TO) begin
        bbl_len = `BBL_CYC_REG; // see RULE2
      end else if (o == `BBL_OP_BIT) begin
        bbl_len = `BBL_CYC_BIT; // see RULE7
      end else if (o == `BBL_OP_PTR_LOAD || o == `BBL_OP_PTR_STORE) begin
        bbl_len = `BBL_CYC_PTR; // see RULE10
      end else if (o == `BBL_OP_SX_LOAD || o == `BBL_OP_SX_STORE) begin
        bbl_len = `BBL_CYC_SX; // see RULE11
      end else if (o == `BBL_OP_LX_LOAD || o == `BBL_OP_LX_STORE) begin
        bbl_len = `BBL_CYC_LX; // see RULE12 RULE14
      end else begin
        bbl_len = `BBL_CYC_NONE;
      end
    end
  endfunction

  // instruction fields of the latched instruction
  wire [7:0] op = ins[7:0];
  wire [7:0] b1 = ins[15:8];
  wire [7:0] b2 = ins[23:16];
  wire [7:0] b3 = ins[31:24];
  wire [3:0] len = bbl_len(op);
  wire [3:0] start_len = bbl_len(INSTR[7:0]);
  wire [3:0] w_hi = b1[7:4];
  wire [3:0] pair = b1[3:0];
  wire [2:0] bit_sel = b1[3:1];

  // operation classes
  wire is_imm = (op[3:0] == `BBL_NIB_IMM);
  wire is_from = (op[3:0] == `BBL_NIB_FROM);
  wire is_to = (op[3:0] == `BBL_NIB_TO);
  wire is_bit = (op == `BBL_OP_BIT);
  wire is_ptr = (op == `BBL_OP_PTR_LOAD) || (op == `BBL_OP_PTR_STORE);
  wire is_sx = (op == `BBL_OP_SX_LOAD) || (op == `BBL_OP_SX_STORE);
  wire is_lx = (op == `BBL_OP_LX_LOAD) || (op == `BBL_OP_LX_STORE);
  wire is_mem = is_ptr || is_sx || is_lx;
  wire mem_store = (op == `BBL_OP_PTR_STORE) || (op == `BBL_OP_SX_STORE) ||
                   (op == `BBL_OP_LX_STORE);
  // under A7/B7 pair 0-1 never indexes; it is the direct address form
  wire is_direct = is_lx && (pair[3:1] == `BBL_DIRECT_PAIR); // see RULE13 RULE14
  wire bit_store = (b1[0] == `BBL_DIR_STORE);

  // working register n sits in the bank picked by the register pointer
  wire [7:0] w_op = {WREG_BASE[7:4], op[7:4]};
  wire [7:0] w_b1 = {WREG_BASE[7:4], w_hi};
  wire [7:0] w_pair_hi = {WREG_BASE[7:4], pair[3:1], 1'b0};
  wire [7:0] w_pair_lo = {WREG_BASE[7:4], pair[3:1], 1'b1};

  // offset carried by the instruction, low byte first for the long forms
  wire [15:0] offset = is_lx ? {b3, b2} :
                       is_sx ? {`BBL_ZERO_BYTE, b2} : `BBL_ZERO_WORD; // see RULE11 RULE12
  wire [15:0] ptr_addr = {a_val, b_val} + offset; // see RULE15
  wire [15:0] eff_addr = is_direct ? offset : ptr_addr; // see RULE14

  // read addresses for the first two operand reads; the third always reads w_b1
  reg [7:0] addr_a;
  reg [7:0] addr_b;
  always @* begin
    addr_a = b1;
    addr_b = w_b1;
    if (is_to) begin
      addr_a = w_op;
    end else if (is_bit) begin
      addr_a = b2;
    end else if (is_mem) begin
      addr_a = w_pair_hi;
      addr_b = w_pair_lo;
    end
  end

  // bit b of the register replaced by bit 0 of the working register
  wire [7:0] merged;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_merge
      assign merged[gi] = (bit_sel == gi) ? b_val[0] : a_val[gi]; // see RULE5 RULE6
    end
  endgenerate

  // write target and value for every form that writes a register
  reg [7:0] next_waddr;
  reg [7:0] next_wdata;
  always @* begin
    next_waddr = w_op;
    next_wdata = a_val; // see RULE1
    if (is_imm) begin
      next_wdata = b1;
    end else if (is_to) begin
      next_waddr = b1;
    end else if (is_bit && bit_store) begin
      next_waddr = b2;
      next_wdata = merged; // see RULE5
    end else if (is_bit) begin
      next_waddr = w_b1;
      next_wdata = {b_val[7:1], a_val[bit_sel]}; // see RULE4 RULE6
    end else if (is_mem) begin
      next_waddr = w_b1;
      next_wdata = mdata; // see RULE8
    end
  end

  assign BUSY = (state == ST_RUN);

  // sequencer: operand reads, memory access, one register write except on memory stores, done
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      ins <= 32'h0000_0000;
      a_val <= 8'h00;
      b_val <= 8'h00;
      mdata <= 8'h00;
      DONE <= 1'b0;
      ILLEGAL <= 1'b0;
      REG_RADDR <= 8'h00;
      REG_WE <= 1'b0;
      REG_WADDR <= 8'h00;
      REG_WDATA <= 8'h00;
      FLAGS_WE <= 1'b0;
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_SPACE <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 8'h00;
    end else begin
      DONE <= 1'b0;
      ILLEGAL <= 1'b0;
      REG_WE <= 1'b0;
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      FLAGS_WE <= 1'b0; // flags are never written by any move; see RULE3
      case (state)
        ST_IDLE: begin
          cnt <= `BBL_CNT_ZERO;
          // a start during a run is ignored; the caller must wait for idle
          if (START) begin
            if (start_len == `BBL_CYC_NONE) begin
              ILLEGAL <= 1'b1;
            end else begin
              ins <= INSTR;
              state <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          cnt <= cnt + `BBL_CNT_STEP;
          // register reads have no latency: data answers the address one cycle on
          if (cnt == `BBL_STEP_RD_A) begin
            REG_RADDR <= addr_a;
          end
          if (cnt == `BBL_STEP_RD_B) begin
            a_val <= REG_RDATA;
            REG_RADDR <= addr_b;
          end
          if (cnt == `BBL_STEP_RD_C) begin
            b_val <= REG_RDATA;
            REG_RADDR <= w_b1;
          end
          // memory access; store data taken straight from the third read
          if (is_mem && cnt == `BBL_STEP_MEM) begin
            MEM_REQ <= 1'b1; // see RULE8
            MEM_WE <= mem_store;
            MEM_SPACE <= pair[0]; // see RULE9 RULE14
            MEM_ADDR <= eff_addr; // see RULE15
            MEM_WDATA <= REG_RDATA;
          end
          if (is_mem && cnt == `BBL_STEP_MDATA) begin
            mdata <= MEM_RDATA;
          end
          // single register write, timed so it lands in the last cycle
          if (cnt == len - `BBL_WRITE_LEAD && !(is_mem && mem_store)) begin
            REG_WE <= 1'b1; // see RULE1 RULE2
            REG_WADDR <= next_waddr;
            REG_WDATA <= next_wdata;
          end
          if (cnt == len - `BBL_DONE_LEAD) begin
            DONE <= 1'b1; // see RULE7 RULE10 RULE11 RULE12
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // bbl_move_unit
`default_nettype wire

//--- bbl_move_unit_assertions.sv
// port-level checks for the move unit
`timescale 1ns/1ps
`default_nettype none
module bbl_move_unit_chk (
  // clock and reset
  input wire CORE_CLK,
  input wire RESET,
  // issue
  input wire START,
  input wire [31:0] INSTR,
  input wire [7:0] WREG_BASE,
  input wire BUSY,
  input wire DONE,
  input wire ILLEGAL,
  // register file and memory
  input wire REG_WE,
  input wire [7:0] REG_WADDR,
  input wire FLAGS_WE,
  input wire MEM_REQ,
  input wire MEM_WE,
  input wire MEM_SPACE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // accepted issue; memory forms listed exactly since C7, D7, E3, F3 are not ours
  wire go = START && !BUSY;
  wire [7:0] op = INSTR[7:0];
  wire mem = go && (op inside {8'hC3, 8'hD3, 8'hE7, 8'hF7, 8'hA7, 8'hB7});
  reg_len_a: assert property (go && (op[3:0] inside {4'hC, 4'h8, 4'h9}) |=> BUSY[*4] ##1 DONE)
    else $error("register load length wrong");
  bit_len_a: assert property (go && op == 8'h47 |=> BUSY[*6] ##1 DONE)
    else $error("bit load length wrong");
  ptr_len_a: assert property (mem && op[7:5] == 3'h6 |-> ##11 DONE)
    else $error("pair indirect length wrong");
  short_len_a: assert property (mem && op[7:5] == 3'h7 |-> ##13 DONE)
    else $error("short indexed length wrong");
  long_len_a: assert property (mem && op[7:5] == 3'h5 |-> ##15 DONE)
    else $error("long indexed length wrong");
  mem_space_a: assert property (mem |-> ##5 MEM_REQ && MEM_WE == $past(INSTR[4], 5) && MEM_SPACE == $past(INSTR[8], 5))
    else $error("memory access kind wrong");
  bit_target_a: assert property (go && op == 8'h47 |-> ##6 REG_WE && REG_WADDR == ($past(INSTR[8], 6) ? $past(INSTR[23:16], 6) : {WREG_BASE[7:4], $past(INSTR[15:12], 6)}))
    else $error("bit load target wrong");
  no_flags_a: assert property (!FLAGS_WE)
    else $error("flag register written");
  bad_op_a: assert property (go && op == 8'h00 |=> ILLEGAL && !BUSY)
    else $error("unknown opcode not refused");
  // main scenarios reached
  cover property (go && op == 8'h47);
  cover property (mem && op[4]);
  cover property (ILLEGAL);
endmodule // bbl_move_unit_chk
bind bbl_move_unit bbl_move_unit_chk chk_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .START(START),
  .INSTR(INSTR), .WREG_BASE(WREG_BASE), .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL),
  .REG_WE(REG_WE), .REG_WADDR(REG_WADDR), .FLAGS_WE(FLAGS_WE), .MEM_REQ(MEM_REQ),
  .MEM_WE(MEM_WE), .MEM_SPACE(MEM_SPACE));
`default_nettype wire

//--- bbl_core_model.sv
// register file and both memory spaces facing the move unit
`timescale 1ns/1ps
`default_nettype none
module bbl_core_model (
  // clock
  input wire CORE_CLK,
  // register file
  input wire [7:0] REG_RADDR,
  output logic [7:0] REG_RDATA,
  input wire REG_WE,
  input wire [7:0] REG_WADDR,
  input wire [7:0] REG_WDATA,
  // memory
  input wire MEM_REQ,
  input wire MEM_WE,
  input wire MEM_SPACE,
  input wire [15:0] MEM_ADDR,
  input wire [7:0] MEM_WDATA,
  output logic [7:0] MEM_RDATA
);
  logic [7:0] regs [0:255];
  logic [7:0] pmem [0:65535];
  logic [7:0] dmem [0:65535];
  // register file answers in the same cycle
  assign REG_RDATA = regs[REG_RADDR];
  initial MEM_RDATA = 8'h00;
  // read data good one cycle only; it toggles otherwise so a late sample is caught
  always @(posedge CORE_CLK) begin
    if (REG_WE) regs[REG_WADDR] <= REG_WDATA;
    if (MEM_REQ && MEM_WE && MEM_SPACE) dmem[MEM_ADDR] <= MEM_WDATA;
    if (MEM_REQ && MEM_WE && !MEM_SPACE) pmem[MEM_ADDR] <= MEM_WDATA;
    MEM_RDATA <= (MEM_REQ && !MEM_WE) ? (MEM_SPACE ? dmem[MEM_ADDR] : pmem[MEM_ADDR]) : ~MEM_RDATA;
  end
endmodule // bbl_core_model
`default_nettype wire

//--- bbl_move_unit_tb.sv
// self-checking bench for the move unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module bbl_move_unit_tb;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic START = 1'b0;
  logic [31:0] INSTR = 32'h0000_0000;
  logic [7:0] WREG_BASE = 8'hC0;
  wire BUSY, DONE, ILLEGAL, REG_WE, FLAGS_WE, MEM_REQ, MEM_WE, MEM_SPACE;
  wire [7:0] REG_RADDR, REG_RDATA, REG_WADDR, REG_WDATA, MEM_WDATA, MEM_RDATA;
  wire [15:0] MEM_ADDR;
  int miscompares = 0;
  int compares = 0;
  bbl_move_unit dut_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .START(START), .INSTR(INSTR),
    .WREG_BASE(WREG_BASE), .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL), .REG_RADDR(REG_RADDR),
    .REG_RDATA(REG_RDATA), .REG_WE(REG_WE), .REG_WADDR(REG_WADDR), .REG_WDATA(REG_WDATA),
    .FLAGS_WE(FLAGS_WE), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_SPACE(MEM_SPACE),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA));
  bbl_core_model mdl_u (.CORE_CLK(CORE_CLK), .REG_RADDR(REG_RADDR), .REG_RDATA(REG_RDATA),
    .REG_WE(REG_WE), .REG_WADDR(REG_WADDR), .REG_WDATA(REG_WDATA), .MEM_REQ(MEM_REQ),
    .MEM_WE(MEM_WE), .MEM_SPACE(MEM_SPACE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA));
  // 100 MHz core clock
  initial forever #5 CORE_CLK = ~CORE_CLK;
  task automatic end_of_test();
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // issue at a falling edge, count cycles until done; the caller may issue again at once
  task automatic issue(input logic [31:0] ins, output int n);
    n = 0;
    INSTR = ins;
    START = 1'b1;
    @(negedge CORE_CLK);
    START = 1'b0;
    while (DONE !== 1'b1 && n < 20) begin
      @(negedge CORE_CLK);
      n++;
    end
    if (n == 20) begin miscompares++; end_of_test(); end
  endtask
  task automatic t_reg();
    int n;
    mdl_u.regs[8'h40] = 8'h77;
    mdl_u.regs[8'hC1] = 8'h3B;
    issue(32'h0000_5A3C, n);
    `CHK(n, 4)
    issue(32'h0000_4028, n);
    issue(32'h0000_4119, n);
    `CHK(mdl_u.regs[8'hC3], 8'h5A)
    `CHK(mdl_u.regs[8'hC2], 8'h77)
    `CHK(mdl_u.regs[8'h40], 8'h77)
    `CHK(mdl_u.regs[8'h41], 8'h3B)
  endtask
  task automatic t_bit();
    int n;
    mdl_u.regs[8'hC0] = 8'h06;
    mdl_u.regs[8'h50] = 8'h05;
    issue(32'h0050_0447, n);
    `CHK(n, 6)
    `CHK(mdl_u.regs[8'hC0], 8'h07)
    `CHK(mdl_u.regs[8'h50], 8'h05)
    mdl_u.regs[8'hC0] = 8'h06;
    issue(32'h0050_0147, n);
    `CHK(mdl_u.regs[8'h50], 8'h04)
    `CHK(mdl_u.regs[8'hC0], 8'h06)
  endtask
  task automatic t_mem();
    int n;
    mdl_u.regs[8'hC0] = 8'h11;
    mdl_u.regs[8'hC2] = 8'h01;
    mdl_u.regs[8'hC3] = 8'h04;
    mdl_u.pmem[16'h0104] = 8'h1A;
    mdl_u.pmem[16'h1104] = 8'h88;
    mdl_u.dmem[16'h0105] = 8'h7D;
    issue(32'h0000_52C3, n);
    `CHK(n, 10)
    `CHK(mdl_u.regs[8'hC5], 8'h1A)
    issue(32'h0000_03D3, n);
    `CHK(mdl_u.dmem[16'h0104], 8'h11)
    issue(32'h0001_63E7, n);
    `CHK(n, 12)
    `CHK(mdl_u.regs[8'hC6], 8'h7D)
    issue(32'h00FF_02F7, n);
    `CHK(mdl_u.pmem[16'h0203], 8'h11)
    issue(32'h1000_72A7, n);
    `CHK(n, 14)
    `CHK(mdl_u.regs[8'hC7], 8'h88)
    issue(32'h1105_01B7, n);
    `CHK(mdl_u.dmem[16'h1105], 8'h11)
    issue(32'h1104_80A7, n);
    `CHK(n, 14)
    `CHK(mdl_u.regs[8'hC8], 8'h88)
    `CHK({mdl_u.regs[8'hC2], mdl_u.regs[8'hC3]}, 16'h0104)
  endtask
  // unknown opcode is refused in cycle zero without going busy
  task automatic t_bad();
    INSTR = 32'h0000_0000;
    START = 1'b1;
    @(negedge CORE_CLK);
    START = 1'b0;
    `CHK({ILLEGAL, BUSY}, 2'b10)
  endtask
  initial begin
    // ten full reset edges, released off the sampling edge
    repeat (10) @(negedge CORE_CLK);
    RESET = 1'b0;
    t_reg();
    t_bit();
    t_mem();
    t_bad();
    end_of_test();
  end
endmodule // bbl_move_unit_tb
`default_nettype wire
